/* hdl/cmp_pkg.sv */
/*
 Constants for the analog comparator control block: register offsets,
 field positions, reset values, interrupt modes and AHB-Lite codes.
 Assumes a single 32-bit AHB-Lite slave port with byte-wide registers.
*/
// ==========================================================================
// Package
package cmp_pkg;

   // ==========================================================================
   // Register byte addresses
   localparam logic [7:0] OFS_CTRL_STATUS = 8'h08;
   localparam logic [7:0] OFS_SPECIAL_IO  = 8'h20;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h30;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h34;

   // ==========================================================================
   // Fields of comparator_ctrl_status
   localparam int unsigned BIT_POWER_OFF = 7;
   localparam int unsigned BIT_BANDGAP   = 6;
   localparam int unsigned BIT_SYNC_OUT  = 5;
   localparam int unsigned BIT_IRQ_FLAG  = 4;
   localparam int unsigned BIT_IRQ_EN    = 3;
   localparam int unsigned BIT_CAPTURE   = 2;
   localparam int unsigned BIT_MODE_HI   = 1;
   localparam int unsigned BIT_MODE_LO   = 0;

   // ==========================================================================
   // Fields of special_function_io
   localparam int unsigned BIT_MUX_EN    = 3;
   localparam logic [7:0]  SFIO_RW_MASK  = 8'h8f;

   // ==========================================================================
   // Interrupt status and mask layout
   localparam int unsigned IRQ_WIDTH      = 2;
   localparam int unsigned IRQ_BIT_EVENT  = 0;
   localparam int unsigned IRQ_BIT_TOGGLE = 1;

   // ==========================================================================
   // Reset values
   localparam logic [7:0]           RST_CTRL = 8'h00;
   localparam logic [7:0]           RST_SFIO = 8'h00;
   localparam logic [IRQ_WIDTH-1:0] RST_IRQ  = 2'h0;

   // ==========================================================================
   // AHB-Lite transfer codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
   localparam logic [1:0] HRESP_OKAY    = 2'h0;

   // ==========================================================================
   // Interrupt modes
   typedef enum logic [1:0] {
      MODE_TOGGLE   = 2'h0,
      MODE_RESERVED = 2'h1,
      MODE_FALL     = 2'h2,
      MODE_RISE     = 2'h3
   } irq_mode_t;

endpackage : cmp_pkg

/* hdl/analog_comparator_control.sv */
/*
 Digital control around an on-chip analog comparator: input selection,
 output synchroniser, edge detection, interrupt flag, capture routing and
 an AHB-Lite register slave.
 Assumes the raw comparator result is asynchronous to hclk, and that the
 converter enable, channel field, global enable and vector acknowledge
 come from logic on hclk.
*/
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps

module analog_comparator_control
   import cmp_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic [1:0]       hresp,
   input  wire logic        cmp_raw,
   input  wire logic        converter_enable,
   input  wire logic [2:0]  converter_channel_select,
   input  wire logic        global_irq_enable,
   input  wire logic        irq_vector_ack,
   output logic             bandgap_positive_select,
   output logic             neg_from_channel,
   output logic [2:0]       neg_channel,
   output logic             cmp_power_off,
   output logic             capture_trigger,
   output logic             cmp_irq_req,
   output logic             irq
);

   // ==========================================================================
   // State
   typedef struct packed {
      logic                 sync1;
      logic                 sync2;
      logic                 prev;
      logic [7:0]           ctrl;
      logic [7:0]           sfio;
      logic [IRQ_WIDTH-1:0] irq_status;
      logic [IRQ_WIDTH-1:0] irq_mask;
      logic                 dp_write;
      logic                 dp_read;
      logic                 dp_wait;
      logic [7:0]           dp_addr;
      logic [31:0]          rdata;
   } state_t;

   localparam state_t STATE_RESET = '{
      sync1:      1'b0,
      sync2:      1'b0,
      prev:       1'b0,
      ctrl:       RST_CTRL,
      sfio:       RST_SFIO,
      irq_status: RST_IRQ,
      irq_mask:   RST_IRQ,
      dp_write:   1'b0,
      dp_read:    1'b0,
      dp_wait:    1'b0,
      dp_addr:    8'h00,
      rdata:      32'h0000_0000
   };

   state_t st_q;
   state_t st_d;

   // ==========================================================================
   // Field views
   logic fld_power_off;
   logic fld_bandgap;
   logic fld_irq_en;
   logic fld_capture;
   logic fld_flag;
   logic fld_mux_en;

   assign fld_power_off = st_q.ctrl[BIT_POWER_OFF];
   assign fld_bandgap   = st_q.ctrl[BIT_BANDGAP];
   assign fld_irq_en    = st_q.ctrl[BIT_IRQ_EN];
   assign fld_capture   = st_q.ctrl[BIT_CAPTURE];
   assign fld_flag      = st_q.ctrl[BIT_IRQ_FLAG];
   assign fld_mux_en    = st_q.sfio[BIT_MUX_EN];

   // ==========================================================================
   // Register read view
   function automatic logic [31:0] read_view(input logic [7:0] addr, input state_t s);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (addr)
         OFS_CTRL_STATUS: begin
            v[7:0]         = s.ctrl;
            v[BIT_SYNC_OUT] = s.sync2;
         end
         OFS_SPECIAL_IO: begin
            v[7:0] = s.sfio & SFIO_RW_MASK;
         end
         OFS_IRQ_STATUS: begin
            v[IRQ_WIDTH-1:0] = s.irq_status;
         end
         OFS_IRQ_MASK: begin
            v[IRQ_WIDTH-1:0] = s.irq_mask;
         end
         default: begin
            v = 32'h0000_0000;
         end
      endcase
      return v;
   endfunction : read_view

   // ==========================================================================
   // Helpers
   // A register is written in its data phase, when hwdata stands
   function automatic logic reg_hit(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
      logic hit;
      hit = wr && (addr == ofs);
      return hit;
   endfunction : reg_hit

   // Set wins over a same-cycle clear, so an event is never lost
   function automatic logic sticky_next(input logic set, input logic q, input logic clr);
      logic nxt;
      nxt = set || (q && !clr);
      return nxt;
   endfunction : sticky_next

   // Only the writable control bits move; output and flag are handled apart
   function automatic logic [7:0] ctrl_write(input logic [7:0] old, input logic [7:0] wdata);
      logic [7:0] c;
      c                = old;
      c[BIT_POWER_OFF] = wdata[BIT_POWER_OFF];
      c[BIT_BANDGAP]   = wdata[BIT_BANDGAP];
      c[BIT_IRQ_EN]    = wdata[BIT_IRQ_EN];
      c[BIT_CAPTURE]   = wdata[BIT_CAPTURE];
      c[BIT_MODE_HI]   = wdata[BIT_MODE_HI];
      c[BIT_MODE_LO]   = wdata[BIT_MODE_LO];
      return c;
   endfunction : ctrl_write

   // Upper address bits must be zero; anything else decodes to no register
   function automatic logic [7:0] map_addr(input logic [31:0] a);
      logic [7:0] m;
      m = a[7:0];
      if (a[31:8] != 24'h00_0000) begin
         m = 8'hff;
      end
      return m;
   endfunction : map_addr

   // ==========================================================================
   // Next state
   logic      addr_take;
   logic      ev_rise;
   logic      ev_fall;
   logic      ev_toggle;
   logic      ev_mode;
   logic      wr_ctrl;
   logic      wr_sfio;
   logic      wr_status;
   logic      wr_mask;
   logic      clr_flag;
   irq_mode_t mode;

   always_comb begin
      st_d      = st_q;
      addr_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

      // ==========================================================================
      // Synchroniser and edge detect
      // Only the second stage reads the first; everything else sees sync2
      st_d.sync1 = cmp_raw;
      st_d.sync2 = st_q.sync1;
      st_d.prev  = st_q.sync2;

      ev_rise   = st_q.sync2 && !st_q.prev;
      ev_fall   = !st_q.sync2 && st_q.prev;
      ev_toggle = st_q.sync2 ^ st_q.prev;

      mode = irq_mode_t'({st_q.ctrl[BIT_MODE_HI], st_q.ctrl[BIT_MODE_LO]});
      case (mode)
         MODE_TOGGLE: begin
            ev_mode = ev_toggle;
         end
         MODE_FALL: begin
            ev_mode = ev_fall;
         end
         MODE_RISE: begin
            ev_mode = ev_rise;
         end
         default: begin
            ev_mode = 1'b0;
         end
      endcase

      // ==========================================================================
      // Register writes
      // Writes land in the data phase, with hwdata
      wr_ctrl   = reg_hit(st_q.dp_write, st_q.dp_addr, OFS_CTRL_STATUS);
      wr_sfio   = reg_hit(st_q.dp_write, st_q.dp_addr, OFS_SPECIAL_IO);
      wr_status = reg_hit(st_q.dp_write, st_q.dp_addr, OFS_IRQ_STATUS);
      wr_mask   = reg_hit(st_q.dp_write, st_q.dp_addr, OFS_IRQ_MASK);

      if (wr_ctrl) begin
         st_d.ctrl = ctrl_write(st_q.ctrl, hwdata[7:0]);
      end
      // The output bit lives in sync2; the stored copy stays zero
      st_d.ctrl[BIT_SYNC_OUT] = 1'b0;

      if (wr_sfio) begin
         st_d.sfio = hwdata[7:0] & SFIO_RW_MASK;
      end

      if (wr_mask) begin
         st_d.irq_mask = hwdata[IRQ_WIDTH-1:0];
      end

      // ==========================================================================
      // Interrupt flags
      // A new event in the clearing cycle keeps the flag set
      clr_flag = irq_vector_ack || (wr_ctrl && hwdata[BIT_IRQ_FLAG]);
      st_d.ctrl[BIT_IRQ_FLAG] = sticky_next(ev_mode, st_q.ctrl[BIT_IRQ_FLAG], clr_flag);
      st_d.irq_status[IRQ_BIT_EVENT]  = sticky_next(ev_mode, st_q.irq_status[IRQ_BIT_EVENT],
                                                    wr_status && hwdata[IRQ_BIT_EVENT]);
      st_d.irq_status[IRQ_BIT_TOGGLE] = sticky_next(ev_toggle, st_q.irq_status[IRQ_BIT_TOGGLE],
                                                    wr_status && hwdata[IRQ_BIT_TOGGLE]);

      // ==========================================================================
      // Bus data phase
      // Reads take one wait state so that a write just before is seen
      // Trade-off: one stall per read buys a registered hrdata
      if (st_q.dp_wait) begin
         st_d.rdata   = read_view(st_q.dp_addr, st_q);
         st_d.dp_wait = 1'b0;
      end
      if (hready) begin
         st_d.dp_write = addr_take && hwrite;
         st_d.dp_read  = addr_take && !hwrite;
         st_d.dp_wait  = addr_take && !hwrite;
         if (addr_take) begin
            st_d.dp_addr = map_addr(haddr);
         end
      end
   end

   // ==========================================================================
   // Registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= STATE_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================================
   // Outputs
   // Only reads stall; writes finish with no wait state
   assign hreadyout = !st_q.dp_wait;
   assign hrdata    = st_q.rdata;
   // Unmapped addresses read zero, so no error response is needed
   assign hresp     = HRESP_OKAY;

   // ==========================================================================
   // Analog selection
   // The result is not forced low while off; it follows the core
   assign cmp_power_off           = fld_power_off;
   assign bandgap_positive_select = fld_bandgap;

   // Converter owns the shared pins while it is on
   assign neg_from_channel = fld_mux_en && !converter_enable;
   assign neg_channel      = neg_from_channel ? converter_channel_select : 3'h0;

   // Synchronised output, so the timer never sees a metastable level
   assign capture_trigger = fld_capture && st_q.sync2;

   // ==========================================================================
   // Interrupts
   assign cmp_irq_req = fld_flag && fld_irq_en && global_irq_enable;
   // Level output; software clears the cause to drop it
   assign irq         = |(st_q.irq_status & st_q.irq_mask);

endmodule : analog_comparator_control

/* verif/cmp_core_model.sv */
/* Behavioural comparator core at the far side of the block.
 Assumes the bench sets the analog levels as plain byte values. */
`timescale 1ns/1ps
// =====
// Core model
module cmp_core_model #(
   parameter logic [7:0] BG_LVL = 8'h80
) (
   input wire logic       bandgap_positive_select,
   input wire logic       neg_from_channel,
   input wire logic [2:0] neg_channel,
   input wire logic       cmp_power_off,
   input wire logic [7:0] pos_lvl,
   input wire logic [7:0] neg_lvl,
   input wire logic [7:0] chan_lvl [8],
   output logic           cmp_raw
);
   logic [7:0] p_lvl;
   logic [7:0] n_lvl;
   assign p_lvl = bandgap_positive_select ? BG_LVL : pos_lvl;
   assign n_lvl = neg_from_channel ? chan_lvl[neg_channel] : neg_lvl;
   // Unpowered core has no valid result; held low
   assign cmp_raw = !cmp_power_off && (p_lvl > n_lvl);
endmodule : cmp_core_model

/* verif/cmp_ctrl_monitor.sv */
/* Port checker for the comparator control block.
 Assumes hready is looped back from hreadyout. */
`timescale 1ns/1ps
// =====
// Checker
module cmp_ctrl_monitor import cmp_pkg::*; (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [1:0]  hresp,
   input wire logic        cmp_raw,
   input wire logic        converter_enable,
   input wire logic [2:0]  converter_channel_select,
   input wire logic        global_irq_enable,
   input wire logic        irq_vector_ack,
   input wire logic        bandgap_positive_select,
   input wire logic        neg_from_channel,
   input wire logic [2:0]  neg_channel,
   input wire logic        cmp_power_off,
   input wire logic        capture_trigger,
   input wire logic        cmp_irq_req
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic req_t;
   assign req_t = hsel && hready && htrans[1];
   a_capture_sync: assert property (capture_trigger |-> $past(cmp_raw, 2)) else $error("early capture");
   a_neg_pin: assert property (converter_enable |-> !neg_from_channel) else $error("mux while on");
   a_chan_follow: assert property (neg_from_channel |-> neg_channel == converter_channel_select)
      else $error("wrong channel");
   a_chan_idle: assert property (!neg_from_channel |-> neg_channel == 3'h0) else $error("channel idle");
   a_req_global: assert property (cmp_irq_req |-> global_irq_enable) else $error("req ungated");
   a_ack_clears: assert property (irq_vector_ack && $past(cmp_raw, 2) == $past(cmp_raw, 3) |=> !cmp_irq_req)
      else $error("ack kept flag");
   a_read_wait: assert property (req_t && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
   a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("bad resp");
   a_ctrl_cause: assert property ($changed(cmp_power_off) || $changed(bandgap_positive_select)
      |-> $past(req_t && hwrite && haddr[7:0] == OFS_CTRL_STATUS, 2)) else $error("ctrl moved");
   c_req: cover property (cmp_irq_req);
   c_cap: cover property (capture_trigger);
   c_ch7: cover property (neg_from_channel && neg_channel == 3'h7);
endmodule : cmp_ctrl_monitor
bind analog_comparator_control cmp_ctrl_monitor u_cmp_ctrl_monitor (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hready, .hreadyout, .hresp, .cmp_raw, .converter_enable, .converter_channel_select,
   .global_irq_enable, .irq_vector_ack, .bandgap_positive_select, .neg_from_channel, .neg_channel,
   .cmp_power_off, .capture_trigger, .cmp_irq_req);

/* verif/analog_comparator_control_bench.sv */
/* Self-checking bench for the comparator control block.
 Assumes one AHB-Lite master (this bench) and the core model. */
`timescale 1ns/1ps
// =====
// Bench
module analog_comparator_control_bench import cmp_pkg::*;;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, cmp_raw, irq, irq_vector_ack;
   logic        converter_enable, global_irq_enable, bandgap_positive_select, neg_from_channel;
   logic        cmp_power_off, capture_trigger, cmp_irq_req;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, hresp;
   logic [2:0]  hsize, converter_channel_select, neg_channel;
   logic [7:0]  pos_lvl, neg_lvl;
   logic [7:0]  chan_lvl [8];
   logic        rf, ff;
   int          num_errors = 0, n_compared = 0, cyc = 0;
   assign hready = hreadyout;
   analog_comparator_control u_analog_comparator_control (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .cmp_raw, .converter_enable,
      .converter_channel_select, .global_irq_enable, .irq_vector_ack, .bandgap_positive_select,
      .neg_from_channel, .neg_channel, .cmp_power_off, .capture_trigger, .cmp_irq_req, .irq);
   cmp_core_model u_cmp_core_model (.bandgap_positive_select, .neg_from_channel, .neg_channel,
      .cmp_power_off, .pos_lvl, .neg_lvl, .chan_lvl, .cmp_raw);
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   // Whole run needs under 2000 cycles
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors++;
         finish_test();
      end
   end
   // =====
   // Tasks
   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // hready is read at the falling edge, where it equals what the next rising edge samples
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      do @(negedge hclk); while (hready !== 1'b1);
      @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(negedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      @(negedge hclk);
   endtask : ahb
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 8'h00);
      check(rd, exp);
   endtask : rdchk
   task automatic lvl(input logic hi);
      @(posedge hclk);
      pos_lvl <= hi ? 8'hf0 : 8'h10;
      repeat (5) @(posedge hclk);
      @(negedge hclk);
   endtask : lvl
   // =====
   // Tests
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      converter_enable = 1'b0;
      converter_channel_select = 3'h0;
      global_irq_enable = 1'b1;
      irq_vector_ack = 1'b0;
      pos_lvl = 8'h10;
      neg_lvl = 8'h80;
      foreach (chan_lvl[i]) chan_lvl[i] = 8'h80;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk(OFS_CTRL_STATUS, RST_CTRL);
      rdchk(OFS_SPECIAL_IO, RST_SFIO);
      rdchk(OFS_IRQ_STATUS, RST_IRQ);
      ahb(1'b1, 12'h100, 8'hff);
      rdchk(12'h100, 32'h0);
      ahb(1'b1, OFS_SPECIAL_IO, 8'hff);
      rdchk(OFS_SPECIAL_IO, SFIO_RW_MASK);
      for (logic [4:0] c = 0; c < 16; c++) begin
         @(posedge hclk);
         converter_channel_select <= c[2:0];
         converter_enable <= c[3];
         @(negedge hclk);
         check(neg_from_channel, !c[3]);
         check(neg_channel, c[3] ? 3'h0 : c[2:0]);
      end
      @(posedge hclk);
      converter_enable <= 1'b0;
      ahb(1'b1, OFS_SPECIAL_IO, 8'h00);
      check(neg_from_channel, 1'b0);
      ahb(1'b1, OFS_CTRL_STATUS, 8'hc0);
      check({bandgap_positive_select, cmp_power_off}, 2'h3);
      rdchk(OFS_CTRL_STATUS, 8'hc0);
      ahb(1'b1, OFS_IRQ_MASK, 8'h01);
      for (logic [2:0] m = 0; m < 4; m++) begin
         rf = (m == 0 || m == 3);
         ff = (m == 0 || m == 2);
         ahb(1'b1, OFS_IRQ_STATUS, 8'h03);
         ahb(1'b1, OFS_CTRL_STATUS, {6'h00, m[1:0]});
         ahb(1'b1, OFS_CTRL_STATUS, 8'h1c | m);
         lvl(1'b1);
         check(cmp_irq_req, rf);
         check(irq, rf);
         check(capture_trigger, 1'b1);
         rdchk(OFS_CTRL_STATUS, 8'h2c | m | (rf ? 8'h10 : 8'h00));
         @(posedge hclk);
         irq_vector_ack <= 1'b1;
         @(posedge hclk);
         irq_vector_ack <= 1'b0;
         @(negedge hclk);
         check(cmp_irq_req, 1'b0);
         lvl(1'b0);
         check(cmp_irq_req, ff);
         ahb(1'b1, OFS_CTRL_STATUS, 8'h18 | m);
         check(cmp_irq_req, 1'b0);
      end
      ahb(1'b1, OFS_IRQ_MASK, 8'h02);
      check(irq, 1'b1);
      ahb(1'b1, OFS_IRQ_MASK, 8'h00);
      check(irq, 1'b0);
      ahb(1'b1, OFS_IRQ_MASK, 8'h02);
      ahb(1'b1, OFS_IRQ_STATUS, 8'h03);
      check(irq, 1'b0);
      @(posedge hclk);
      global_irq_enable <= 1'b0;
      ahb(1'b1, OFS_CTRL_STATUS, 8'h1b);
      lvl(1'b1);
      check(cmp_irq_req, 1'b0);
      check(capture_trigger, 1'b0);
      rdchk(OFS_CTRL_STATUS, 8'h3b);
      @(posedge hclk);
      global_irq_enable <= 1'b1;
      @(negedge hclk);
      check(cmp_irq_req, 1'b1);
      finish_test();
   end
endmodule : analog_comparator_control_bench
